// ### rtl/chop_lo_pkg.sv
package chop_lo_pkg;

  // chop divider counts half periods of the divider-chain clock
  localparam int unsigned CHOP_CNT_W = 5;
  localparam logic [4:0] DIV_LOW_LONG = 5'h0C;
  localparam logic [4:0] DIV_LOW_SHORT = 5'h03;
  localparam logic [4:0] DIV_HIGH_LONG = 5'h10;
  localparam logic [4:0] DIV_HIGH_SHORT = 5'h04;
  localparam logic [4:0] CHOP_CNT_ONE = 5'h01;
  localparam logic [4:0] CHOP_CNT_RESET = 5'h00;

  // one sample period is two half periods of the divider-chain clock
  localparam logic [1:0] SYNC_HALVES = 2'h2;
  localparam logic [1:0] SYNC_CNT_ONE = 2'h1;
  localparam logic [1:0] SYNC_CNT_RESET = 2'h0;

  // clock-like pins, sampled as one synchroniser group
  localparam int unsigned CK_W = 4;
  localparam int unsigned CK_DIV = 0;
  localparam int unsigned CK_FAST = 1;
  localparam int unsigned CK_REF = 2;
  localparam int unsigned CK_TWICE = 3;

  // static level pins, sampled as a second group
  localparam int unsigned RELAY_W = 3;
  localparam int unsigned RELAY_IMP = 0;
  localparam int unsigned RELAY_ATTEN = 1;
  localparam int unsigned RELAY_GAIN = 2;
  localparam int unsigned LV_W = 7;
  localparam int unsigned LV_OCT = 0;
  localparam int unsigned LV_TC = 1;
  localparam int unsigned LV_PEAK_HI = 2;
  localparam int unsigned LV_PEAK_LO = 3;
  localparam int unsigned LV_RELAY = 4;

  // lo return pairs: inphase p, inphase n, quad p, quad n
  localparam int unsigned RET_W = 4;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LO_IDLE_NS = 2000;
  localparam int unsigned RET_FAULT_NS = 500;
  localparam int unsigned MON_CNT_W = 8;
  localparam logic [7:0] LO_IDLE_CYCLES =
    8'((LO_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RET_FAULT_CYCLES =
    8'((RET_FAULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] MON_CNT_ONE = 8'h01;
  localparam logic [7:0] MON_CNT_RESET = 8'h00;

  function automatic logic [4:0] chop_divisor(input logic oct_half,
                                              input logic short_tc);
    logic [4:0] div;
    div = oct_half ? (short_tc ? DIV_HIGH_SHORT : DIV_HIGH_LONG)
                   : (short_tc ? DIV_LOW_SHORT : DIV_LOW_LONG);
    return div;
  endfunction

endpackage

// ### rtl/edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_clk, // system clock
  input wire logic i_rst, // async reset, active high
  input wire logic [W-1:0] i_async, // pins from outside the domain
  output logic [W-1:0] o_level, // synchronised level
  output logic [W-1:0] o_rise, // one-cycle rising-edge pulse
  output logic [W-1:0] o_fall // one-cycle falling-edge pulse
);

  logic [W-1:0] meta_q;
  logic [W-1:0] level_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      level_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= i_async;
      level_q <= meta_q;
      prev_q <= level_q;
    end
  end

  assign o_level = level_q;
  assign o_rise = level_q & ~prev_q;
  assign o_fall = ~level_q & prev_q;

endmodule // edge_sync
`default_nettype wire

// ### rtl/chop_divider.sv
`timescale 1ns/1ps
`default_nettype none
module chop_divider
  import chop_lo_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_step, // one pulse per divider-chain half period
  input wire logic i_octave_half_sel, // upper half of octave
  input wire logic i_short_tc_sel, // short time constant
  output logic o_chop, // symmetric chop square wave
  output logic o_sync // high for one sample period
);

  logic [4:0] half_cnt_q;
  logic [4:0] half_cnt_d;
  logic chop_q;
  logic chop_d;
  logic sync_q;
  logic sync_d;
  logic [1:0] sync_cnt_q;
  logic [1:0] sync_cnt_d;

  wire [4:0] divisor =
    chop_divisor(i_octave_half_sel, i_short_tc_sel); // [R2] [R3] [R16]
  // shrinking divisor mid-phase still wraps on the next step
  wire last_half = (half_cnt_q >= (divisor - CHOP_CNT_ONE)); // [R1]
  wire wrap = i_step & last_half;
  wire chop_rise = wrap & ~chop_q;
  wire sync_end = (sync_cnt_q == (SYNC_HALVES - SYNC_CNT_ONE));

  // each phase lasts divisor half periods, so odd divisors stay symmetric
  assign half_cnt_d = wrap ? CHOP_CNT_RESET // [R4]
                    : (i_step ? half_cnt_q + CHOP_CNT_ONE : half_cnt_q);
  assign chop_d = wrap ? ~chop_q : chop_q; // [R1] [R4]
  assign sync_d = chop_rise ? 1'b1
                : ((sync_q & i_step & sync_end) ? 1'b0 : sync_q); // [R5]
  assign sync_cnt_d = chop_rise ? SYNC_CNT_RESET
                    : ((sync_q & i_step) ? sync_cnt_q + SYNC_CNT_ONE
                                         : sync_cnt_q); // [R5]

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      half_cnt_q <= CHOP_CNT_RESET; // [R16]
      chop_q <= 1'b0;
      sync_q <= 1'b0;
      sync_cnt_q <= SYNC_CNT_RESET;
    end else begin
      half_cnt_q <= half_cnt_d;
      chop_q <= chop_d;
      sync_q <= sync_d;
      sync_cnt_q <= sync_cnt_d;
    end
  end

  assign o_chop = chop_q;
  assign o_sync = sync_q;

endmodule // chop_divider
`default_nettype wire

// ### rtl/chop_lo_generator.sv
// How it works
// R1 - chop derives from the 49-98 kHz divider clock by integer division
// R2 - lower octave half: divide by 12, or 3 with short time constant
// R3 - upper octave half: divide by 16, or 4 with short time constant
// R4 - chop is a symmetric square wave for every divisor
// R5 - sync output stays high exactly one data sample period
// R6 - chop is retimed on the 6-12 MHz divider clock before mixing
// R7 - chopped reference is chop XOR reference
// R8 - inphase flop on rising, quad on falling twice-ref edge, inverted data
// R9 - both lo drives leave as balanced pairs; returns terminate here
// R10 - impedance relay picks low-z attenuator or high-z preamp path
// R11 - host logic sets the 20 dB attenuator relay from reserve/sensitivity
// R12 - host logic sets the 20 dB gain relay from reserve/sensitivity
// R13 - overload flag goes low when either peak comparator trips
// R14 - host supplies three relay bits and reads the overload flag
// R15 - octave half select is low in lower half, high in upper half
// R16 - reset clears divider and true lo flops, sets the complement lo flops high; divisor follows current inputs
`timescale 1ns/1ps
`default_nettype none
module chop_lo_generator
  import chop_lo_pkg::*;
(
  input wire logic i_clk, // 100 MHz system clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_div_chain_clk, // 49-98 kHz divider-chain output
  input wire logic i_fast_chain_clk, // 6-12 MHz divider-chain output
  input wire logic i_ref_freq, // reference-frequency square wave
  input wire logic i_twice_ref_clk, // twice the reference frequency
  input wire logic i_octave_half_sel, // high in upper half of octave
  input wire logic i_short_tc_sel, // short time constant selected
  input wire logic [2:0] i_relay_ctrl_bits, // relay bits from host
  input wire logic i_peak_hi_trip, // max-peak comparator exceeded
  input wire logic i_peak_lo_trip, // min-peak comparator exceeded
  input wire logic i_inphase_lo_return_p, // inphase return, true
  input wire logic i_inphase_lo_return_n, // inphase return, complement
  input wire logic i_quad_lo_return_p, // quad return, true
  input wire logic i_quad_lo_return_n, // quad return, complement
  output logic o_chop, // retimed chop square wave
  output logic o_chop_sync, // one sample period per chop cycle
  output logic o_chopped_ref, // reference chopped at the i.f.
  output logic o_inphase_lo_drive_p, // inphase lo, true
  output logic o_inphase_lo_drive_n, // inphase lo, complement
  output logic o_quad_lo_drive_p, // quad lo, true
  output logic o_quad_lo_drive_n, // quad lo, complement
  output logic o_high_z_path, // impedance relay: 1 high-z preamp
  output logic o_atten_relay, // 1 inserts 20 dB attenuation
  output logic o_gain_relay, // 1 inserts 20 dB gain
  output logic o_input_overload_n, // low while input overloaded
  output logic o_octave_half_status, // synchronised octave half
  output logic o_lo_active, // twice-ref clock is toggling
  output logic o_lo_return_fault // a return pair lost its balance
);

  // input synchronisers
  logic [CK_W-1:0] ck_level;
  logic [CK_W-1:0] ck_rise;
  logic [CK_W-1:0] ck_fall;
  logic [LV_W-1:0] lv_level;
  logic [RET_W-1:0] ret_level;

  edge_sync #(
    .W(CK_W)
  ) u_clk_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_twice_ref_clk, i_ref_freq, i_fast_chain_clk,
              i_div_chain_clk}),
    .o_level(ck_level),
    .o_rise(ck_rise),
    .o_fall(ck_fall)
  );

  edge_sync #(
    .W(LV_W)
  ) u_level_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_relay_ctrl_bits, i_peak_lo_trip, i_peak_hi_trip,
              i_short_tc_sel, i_octave_half_sel}),
    .o_level(lv_level),
    .o_rise(),
    .o_fall()
  );

  edge_sync #(
    .W(RET_W)
  ) u_return_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_quad_lo_return_n, i_quad_lo_return_p,
              i_inphase_lo_return_n, i_inphase_lo_return_p}),
    .o_level(ret_level),
    .o_rise(),
    .o_fall()
  );

  // decoded pin views
  wire div_half_step = ck_rise[CK_DIV] | ck_fall[CK_DIV]; // [R1]
  wire fast_tick = ck_rise[CK_FAST];
  wire ref_level = ck_level[CK_REF];
  wire twice_rise = ck_rise[CK_TWICE];
  wire twice_fall = ck_fall[CK_TWICE];
  wire twice_edge = twice_rise | twice_fall;
  wire oct_half = lv_level[LV_OCT]; // [R15]
  wire short_tc = lv_level[LV_TC];
  wire [RELAY_W-1:0] relay_bits = lv_level[LV_RELAY +: RELAY_W]; // [R14]
  wire overload_any = lv_level[LV_PEAK_HI] | lv_level[LV_PEAK_LO]; // [R13]

  // chop divider
  logic chop_raw;
  logic sync_raw;

  chop_divider u_chop_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_step(div_half_step),
    .i_octave_half_sel(oct_half),
    .i_short_tc_sel(short_tc),
    .o_chop(chop_raw),
    .o_sync(sync_raw)
  );

  // chop retiming and reference chopping
  logic chop_q;
  logic chop_d;
  logic chop_sync_q;
  logic chopped_ref_q;
  logic chopped_ref_d;

  // chop only moves on a fast divider-chain edge
  assign chop_d = fast_tick ? chop_raw : chop_q; // [R6]
  assign chopped_ref_d = chop_q ^ ref_level; // [R7]

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      chop_q <= 1'b0;
    end else begin
      chop_q <= chop_d; // [R6]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      chop_sync_q <= 1'b0;
    end else begin
      chop_sync_q <= sync_raw; // [R5]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      chopped_ref_q <= 1'b0;
    end else begin
      chopped_ref_q <= chopped_ref_d; // [R7]
    end
  end

  // quadrature lo flops
  logic inphase_q;
  logic inphase_d;
  logic quad_q;
  logic quad_d;
  logic inphase_n_q;
  logic quad_n_q;

  // opposite twice-ref edges give 90 degrees at the reference
  assign inphase_d = twice_rise ? chopped_ref_q : inphase_q; // [R8]
  assign quad_d = twice_fall ? ~chopped_ref_q : quad_q; // [R8]

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      inphase_q <= 1'b0; // [R16]
    end else begin
      inphase_q <= inphase_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      quad_q <= 1'b0; // [R16]
    end else begin
      quad_q <= quad_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      inphase_n_q <= 1'b1;
    end else begin
      inphase_n_q <= ~inphase_d; // [R9]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      quad_n_q <= 1'b1;
    end else begin
      quad_n_q <= ~quad_d; // [R9]
    end
  end

  // relays and overload flag
  logic high_z_q;
  logic atten_q;
  logic gain_q;
  logic overload_n_q;
  logic oct_status_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      high_z_q <= 1'b0;
    end else begin
      high_z_q <= relay_bits[RELAY_IMP]; // [R10]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      atten_q <= 1'b0;
    end else begin
      atten_q <= relay_bits[RELAY_ATTEN]; // [R11]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gain_q <= 1'b0;
    end else begin
      gain_q <= relay_bits[RELAY_GAIN]; // [R12]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      overload_n_q <= 1'b1;
    end else begin
      overload_n_q <= ~overload_any; // [R13]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      oct_status_q <= 1'b0;
    end else begin
      oct_status_q <= oct_half; // [R15]
    end
  end

  // lo activity and return-pair monitors
  logic [MON_CNT_W-1:0] idle_cnt_q;
  logic [MON_CNT_W-1:0] idle_cnt_d;
  logic lo_active_q;
  logic [MON_CNT_W-1:0] ret_cnt_q;
  logic [MON_CNT_W-1:0] ret_cnt_d;
  logic ret_fault_q;

  wire idle_full = (idle_cnt_q >= LO_IDLE_CYCLES);
  // a balanced pair never shows equal levels for long
  wire ret_unbalanced = (ret_level[0] == ret_level[1])
                      | (ret_level[2] == ret_level[3]); // [R9]
  wire ret_full = (ret_cnt_q >= RET_FAULT_CYCLES);

  assign idle_cnt_d = twice_edge ? MON_CNT_RESET
                    : (idle_full ? idle_cnt_q : idle_cnt_q + MON_CNT_ONE);
  assign ret_cnt_d = ~ret_unbalanced ? MON_CNT_RESET
                   : (ret_full ? ret_cnt_q : ret_cnt_q + MON_CNT_ONE);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_cnt_q <= LO_IDLE_CYCLES;
    end else begin
      idle_cnt_q <= idle_cnt_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lo_active_q <= 1'b0;
    end else begin
      lo_active_q <= ~(idle_cnt_d >= LO_IDLE_CYCLES);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ret_cnt_q <= MON_CNT_RESET;
    end else begin
      ret_cnt_q <= ret_cnt_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ret_fault_q <= 1'b0;
    end else begin
      ret_fault_q <= (ret_cnt_d >= RET_FAULT_CYCLES); // [R9]
    end
  end

  // outputs
  assign o_chop = chop_q;
  assign o_chop_sync = chop_sync_q;
  assign o_chopped_ref = chopped_ref_q;
  assign o_inphase_lo_drive_p = inphase_q;
  assign o_inphase_lo_drive_n = inphase_n_q;
  assign o_quad_lo_drive_p = quad_q;
  assign o_quad_lo_drive_n = quad_n_q;
  assign o_high_z_path = high_z_q;
  assign o_atten_relay = atten_q;
  assign o_gain_relay = gain_q;
  assign o_input_overload_n = overload_n_q;
  assign o_octave_half_status = oct_status_q;
  assign o_lo_active = lo_active_q;
  assign o_lo_return_fault = ret_fault_q;

endmodule // chop_lo_generator
`default_nettype wire

// ### bench/chop_lo_far.sv
`timescale 1ns/1ps
`default_nettype none
module chop_lo_far (
  input wire logic i_clk, // system clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_run, // 0 stops the reference clocks
  input wire logic i_cut, // 1 breaks both return pairs
  input wire logic [3:0] i_drive, // lo drives: ip, in, qp, qn
  output logic o_div, // divider-chain clock, 8-cycle half period
  output logic o_fast, // fast divider-chain clock
  output logic o_ref, // reference square wave
  output logic o_twice, // twice-reference clock
  output logic [3:0] o_ret // returned lo pairs
);
  logic [7:0] cnt_q;
  logic [3:0] ref_q;
  logic [3:0] ret_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 8'h00;
      ref_q <= 4'h0;
      ret_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      ref_q <= i_run ? ref_q + 4'h1 : ref_q; // clocks stand still when off
      ret_q <= i_cut ? 4'h0 : i_drive; // terminated and looped back
    end
  end
  assign o_div = cnt_q[3];
  assign o_fast = cnt_q[2];
  assign o_twice = ref_q[2];
  assign o_ref = ref_q[3];
  assign o_ret = ret_q;
endmodule // chop_lo_far
`default_nettype wire

// ### bench/chop_lo_generator_props.sv
`timescale 1ns/1ps
`default_nettype none
module chop_lo_props (
  input wire logic i_clk, // clock
  input wire logic i_rst, // reset
  input wire logic i_fast_chain_clk, // watched
  input wire logic i_ref_freq, // watched
  input wire logic i_twice_ref_clk, // watched
  input wire logic i_octave_half_sel, // watched
  input wire logic [2:0] i_relay_ctrl_bits, // watched
  input wire logic i_peak_hi_trip, // watched
  input wire logic i_peak_lo_trip, // watched
  input wire logic o_chop, // watched
  input wire logic o_chop_sync, // watched
  input wire logic o_chopped_ref, // watched
  input wire logic o_inphase_lo_drive_p, // watched
  input wire logic o_inphase_lo_drive_n, // watched
  input wire logic o_quad_lo_drive_p, // watched
  input wire logic o_quad_lo_drive_n, // watched
  input wire logic o_high_z_path, // watched
  input wire logic o_atten_relay, // watched
  input wire logic o_gain_relay, // watched
  input wire logic o_input_overload_n, // watched
  input wire logic o_octave_half_status // watched
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // cycles since a pin edge, saturating
  logic fast_q, twice_q;
  logic [3:0] fast_age_q, rise_age_q, fall_age_q;
  logic [3:0] fast_age_d, rise_age_d, fall_age_d;
  assign fast_age_d = (i_fast_chain_clk && !fast_q) ? 4'h0
    : fast_age_q + {3'h0, fast_age_q != 4'hF};
  assign rise_age_d = (i_twice_ref_clk && !twice_q) ? 4'h0
    : rise_age_q + {3'h0, rise_age_q != 4'hF};
  assign fall_age_d = (!i_twice_ref_clk && twice_q) ? 4'h0
    : fall_age_q + {3'h0, fall_age_q != 4'hF};
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {fast_q, twice_q} <= 2'h0;
      {fast_age_q, rise_age_q, fall_age_q} <= 12'hFFF;
    end else begin
      {fast_q, twice_q} <= {i_fast_chain_clk, i_twice_ref_clk};
      {fast_age_q, rise_age_q, fall_age_q} <=
        {fast_age_d, rise_age_d, fall_age_d};
    end
  end
  sequence s_quiet;
    ($stable(i_ref_freq) && $stable(o_chop)) [*6];
  endsequence
  sequence s_chop_up;
    ##[0:16] $rose(o_chop);
  endsequence
  a_inphase_pair: assert property (
    o_inphase_lo_drive_p != o_inphase_lo_drive_n)
    else $error("inphase drive pair not balanced");
  a_quad_pair: assert property (
    o_quad_lo_drive_p != o_quad_lo_drive_n)
    else $error("quad drive pair not balanced");
  a_overload_set: assert property (
    (i_peak_hi_trip || i_peak_lo_trip) [*5] |-> !o_input_overload_n)
    else $error("overload flag missed a trip");
  a_overload_clear: assert property (
    (!i_peak_hi_trip && !i_peak_lo_trip) [*5] |-> o_input_overload_n)
    else $error("overload flag low without trip");
  a_relay_follow: assert property (
    $stable(i_relay_ctrl_bits) [*5] |->
      {o_gain_relay, o_atten_relay, o_high_z_path} == i_relay_ctrl_bits)
    else $error("relay drives differ from control bits");
  a_octave_follow: assert property (
    $stable(i_octave_half_sel) [*5] |->
      o_octave_half_status == i_octave_half_sel)
    else $error("octave status differs from select");
  a_chop_retime: assert property (
    $changed(o_chop) |-> fast_age_q inside {[2:6]})
    else $error("chop moved away from a fast clock rise");
  a_sync_chop: assert property (
    $rose(o_chop_sync) |-> s_chop_up)
    else $error("sync not aligned to chop rise");
  a_chopped_xor: assert property (
    s_quiet |-> o_chopped_ref == (o_chop ^ i_ref_freq))
    else $error("chopped reference is not chop xor reference");
  a_inphase_edge: assert property (
    $changed(o_inphase_lo_drive_p) |-> rise_age_q inside {[2:6]})
    else $error("inphase drive moved off a rising edge");
  a_quad_edge: assert property (
    $changed(o_quad_lo_drive_p) |-> fall_age_q inside {[2:6]})
    else $error("quad drive moved off a falling edge");
endmodule // chop_lo_props
bind chop_lo_generator chop_lo_props u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_fast_chain_clk(i_fast_chain_clk),
  .i_ref_freq(i_ref_freq), .i_twice_ref_clk(i_twice_ref_clk),
  .i_octave_half_sel(i_octave_half_sel),
  .i_relay_ctrl_bits(i_relay_ctrl_bits), .i_peak_hi_trip(i_peak_hi_trip),
  .i_peak_lo_trip(i_peak_lo_trip), .o_chop(o_chop),
  .o_chop_sync(o_chop_sync), .o_chopped_ref(o_chopped_ref),
  .o_inphase_lo_drive_p(o_inphase_lo_drive_p),
  .o_inphase_lo_drive_n(o_inphase_lo_drive_n),
  .o_quad_lo_drive_p(o_quad_lo_drive_p),
  .o_quad_lo_drive_n(o_quad_lo_drive_n), .o_high_z_path(o_high_z_path),
  .o_atten_relay(o_atten_relay), .o_gain_relay(o_gain_relay),
  .o_input_overload_n(o_input_overload_n),
  .o_octave_half_status(o_octave_half_status)
);
`default_nettype wire

// ### bench/tb_chop_lo_generator.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_chop_lo_generator;
  logic clk, rst, divc, fast, refc, twice, oct, tc, hi, lo, run, cut;
  logic [2:0] bits;
  wire [3:0] drv;
  logic [3:0] ret;
  logic chop, sync, cref, hiz, atten, gain, ovl_n, octst, lo_act, fault;
  int mismatches = 0;
  int samples_checked = 0;
  int divs [4] = '{12, 3, 16, 4};
  chop_lo_generator dut (
    .i_clk(clk), .i_rst(rst), .i_div_chain_clk(divc),
    .i_fast_chain_clk(fast), .i_ref_freq(refc), .i_twice_ref_clk(twice),
    .i_octave_half_sel(oct), .i_short_tc_sel(tc), .i_relay_ctrl_bits(bits),
    .i_peak_hi_trip(hi), .i_peak_lo_trip(lo),
    .i_inphase_lo_return_p(ret[0]), .i_inphase_lo_return_n(ret[1]),
    .i_quad_lo_return_p(ret[2]), .i_quad_lo_return_n(ret[3]),
    .o_chop(chop), .o_chop_sync(sync), .o_chopped_ref(cref),
    .o_inphase_lo_drive_p(drv[0]), .o_inphase_lo_drive_n(drv[1]),
    .o_quad_lo_drive_p(drv[2]), .o_quad_lo_drive_n(drv[3]),
    .o_high_z_path(hiz), .o_atten_relay(atten), .o_gain_relay(gain),
    .o_input_overload_n(ovl_n), .o_octave_half_status(octst),
    .o_lo_active(lo_act), .o_lo_return_fault(fault)
  );
  chop_lo_far far (
    .i_clk(clk), .i_rst(rst), .i_run(run), .i_drive(drv), .o_div(divc),
    .o_fast(fast), .o_ref(refc), .o_twice(twice), .o_ret(ret), .i_cut(cut)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic results();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // counts cycles until chop (s=0) or sync (s=1) equals v
  task automatic wt(input int s, input logic v, output int n);
    n = 0;
    while (((s == 0) ? chop : sync) !== v && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 1000) begin
      mismatches++;
      results();
    end
  endtask
  initial begin
    int n, h, l, sw, rest, d;
    rst = 1'b1;
    {oct, tc, hi, lo, bits} = 7'h00;
    run = 1'b1;
    cut = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK(drv, 4'hA)
    `CHK({chop, sync, ovl_n}, 3'h1)
    @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      bits <= 3'(i);
      repeat (5) @(posedge clk);
      #1;
      `CHK({gain, atten, hiz}, 3'(i))
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {hi, lo} <= 2'(i);
      repeat (5) @(posedge clk);
      #1;
      `CHK(ovl_n, 1'(i == 0))
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {oct, tc} <= 2'(i);
      d = divs[i];
      repeat (2) begin
        wt(1, 1'b0, n);
        wt(1, 1'b1, n);
      end
      wt(1, 1'b0, sw);
      wt(1, 1'b1, rest);
      `CHK(sw, 16)
      `CHK(sw + rest, 16 * d)
      wt(0, 1'b0, n);
      wt(0, 1'b1, n);
      wt(0, 1'b0, h);
      wt(0, 1'b1, l);
      `CHK(h, 8 * d)
      `CHK(l, 8 * d)
      `CHK(octst, oct)
    end
    `CHK(lo_act, 1'b1)
    @(posedge clk);
    run <= 1'b0;
    repeat (250) @(posedge clk);
    #1;
    `CHK(lo_act, 1'b0)
    @(posedge clk);
    run <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    `CHK(lo_act, 1'b1)
    `CHK(fault, 1'b0)
    @(posedge clk);
    cut <= 1'b1;
    repeat (60) @(posedge clk);
    #1;
    `CHK(fault, 1'b1)
    @(posedge clk);
    cut <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    `CHK(fault, 1'b0)
    results();
  end
endmodule // tb_chop_lo_generator
`default_nettype wire
